// ---- rtl/ddsl_top.sv ----
// Serial input, framing and load control of a dual current-output converter.
// Assumes the host drives sclk, sync_n, serial_in and load_strobe_n asynchronously.
`timescale 1ns/1ps
`default_nettype none
module ddsl_top
  import ddsl_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Serial pins from the host
  input wire logic i_sclk,
  input wire logic i_sync_n,
  input wire logic i_serial_in,
  input wire logic i_load_strobe_n,
  output logic o_serial_out,
  // Converter register and update stream
  output logic [WORD_W-1:0] o_dac_code,
  output logic o_dac_valid,
  output logic [WORD_W-1:0] o_dac_data,
  input wire logic i_dac_ready,
  // Status
  output logic o_rising_sel,
  output logic o_daisy_mode,
  output logic o_update_pending
);

  // ------------------------------------------------------------
  // Pin synchronisers and edge finders
  // ------------------------------------------------------------
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [3:0] pin_prev;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pin_meta <= PIN_RST;
      pin_sync <= PIN_RST;
      pin_prev <= PIN_RST;
    end else begin
      pin_meta <= {i_load_strobe_n, i_sync_n, i_sclk, i_serial_in};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  wire din = pin_sync[0];
  wire sclk_rise = pin_sync[1] & ~pin_prev[1];
  wire sclk_fall = ~pin_sync[1] & pin_prev[1];
  wire frame_start = ~pin_sync[2] & pin_prev[2];
  wire frame_end = pin_sync[2] & ~pin_prev[2];
  wire load_fall = ~pin_sync[3] & pin_prev[3];
  // Held low for two samples means the strobe is parked low, not just falling.
  wire auto_mode = ~pin_sync[3] & ~pin_prev[3];

  // ------------------------------------------------------------
  // Edge selection and frame control
  // ------------------------------------------------------------
  logic rising_sel;
  logic daisy;
  ddsl_frame_t state;
  ddsl_frame_t next_state;
  logic [4:0] edge_cnt;
  logic [WORD_W-1:0] shreg;

  wire active_edge = rising_sel ? sclk_rise : sclk_fall;
  wire out_edge = rising_sel ? sclk_fall : sclk_rise;
  wire in_shift = (state == ST_SHIFT);
  wire do_shift = in_shift & active_edge;
  wire [WORD_W-1:0] shifted = {shreg[WORD_W-2:0], din};
  wire last_edge = do_shift & ~daisy & (edge_cnt == LAST_EDGE);
  wire daisy_end = in_shift & daisy & frame_end;
  wire latch_go = last_edge | daisy_end;
  wire [WORD_W-1:0] word_now = last_edge ? shifted : shreg;
  wire is_ctrl = (word_now[CTRL_MSB:CTRL_LSB] == CTRL_CODE);
  wire data_latch = latch_go & ~is_ctrl;
  wire ctrl_latch = latch_go & is_ctrl;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (frame_start) begin
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (frame_end) begin
          next_state = ST_IDLE;
        end else if (last_edge) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (frame_end) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      edge_cnt <= CNT_RST;
    end else begin
      state <= next_state;
      if (frame_start) begin
        edge_cnt <= CNT_RST;
      end else if (do_shift) begin
        edge_cnt <= edge_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      shreg <= WORD_RST;
      o_serial_out <= 1'b0;
    end else begin
      if (do_shift) begin
        shreg <= shifted;
      end
      if (in_shift & out_edge) begin
        o_serial_out <= shreg[WORD_W-1];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rising_sel <= RISING_RST;
      daisy <= DAISY_RST;
    end else if (ctrl_latch) begin
      rising_sel <= word_now[EDGE_BIT];
      daisy <= word_now[DAISY_BIT];
    end
  end

  // ------------------------------------------------------------
  // Input buffer and converter update
  // ------------------------------------------------------------
  logic [WORD_W-1:0] buf_word;
  logic pend;
  logic fifo_ready;

  // An update waits in pend while the FIFO is full; a second load event before the push merges into it.
  wire upd_req = load_fall | (data_latch & auto_mode);
  wire push = pend & fifo_ready;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      buf_word <= WORD_RST;
      pend <= 1'b0;
      o_dac_code <= WORD_RST;
    end else begin
      if (data_latch) begin
        buf_word <= word_now;
      end
      pend <= (pend & ~push) | upd_req;
      if (push) begin
        o_dac_code <= buf_word;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_rising_sel <= RISING_RST;
      o_daisy_mode <= DAISY_RST;
      o_update_pending <= 1'b0;
    end else begin
      o_rising_sel <= rising_sel;
      o_daisy_mode <= daisy;
      o_update_pending <= pend;
    end
  end

  ddsl_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_valid(pend),
    .i_data(buf_word),
    .o_ready(fifo_ready),
    .o_valid(o_dac_valid),
    .o_data(o_dac_data),
    .i_ready(i_dac_ready)
  );

endmodule : ddsl_top
`default_nettype wire

// ---- pkg/ddsl_pkg.sv ----
// Constants and types of the dual converter serial load front end.
// Assumes a single 250 MHz clock; all serial pins arrive from outside its domain.
//
// Summary of operation
// - A falling load strobe edge moves the buffered word into the converter register.
// - Load strobe held low selects automatic update instead of waiting for an edge.
// - Automatic standalone update happens on the 16th active serial clock edge.
// - Automatic daisy-chain update happens when the frame select returns high.
// - After reset, serial data is sampled on falling serial clock edges.
// - A control word from the host may switch sampling to rising edges.
// - Serial data is held in a 16-bit shift register, one bit per active edge.
// - Frame select low opens the input path; host starts each frame that way.
// - Standalone mode counts active edges and latches the word on the 16th.
// - Serial output changes on the edge opposite the sampling edge, for chaining.
package ddsl_pkg;

  // ------------------------------------------------------------
  // Word and buffer shape
  // ------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] LAST_EDGE = 5'h0f;
  localparam logic [4:0] CNT_RST = 5'h00;

  // ------------------------------------------------------------
  // Control word layout
  // ------------------------------------------------------------
  localparam int CTRL_MSB = 15;
  localparam int CTRL_LSB = 12;
  localparam logic [3:0] CTRL_CODE = 4'hd;
  localparam int EDGE_BIT = 0;
  localparam int DAISY_BIT = 1;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic RISING_RST = 1'b0;
  localparam logic DAISY_RST = 1'b0;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  // Pin order in the synchroniser: load_strobe_n, sync_n, sclk, serial_in.
  localparam logic [3:0] PIN_RST = 4'hc;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE = 3'b100
  } ddsl_frame_t;

endpackage : ddsl_pkg

// ---- rtl/ddsl_fifo.sv ----
// Word FIFO with a registered head, between load events and the converter.
// Assumes both sides run on i_mclk; the reader may stall at will.
`timescale 1ns/1ps
`default_nettype none
module ddsl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  wire push = i_valid & o_ready;
  wire pop = (count != '0) & (~o_valid | i_ready);
  wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_ready <= 1'b1;
      o_valid <= 1'b0;
      o_data <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= next_count;
      // A registered full flag taken from next_count uses all DEPTH slots and keeps o_ready off the read path.
      o_ready <= (next_count < (AW+1)'(DEPTH));
      if (pop) begin
        o_valid <= 1'b1;
        o_data <= mem[rd_ptr];
      end else if (i_ready) begin
        o_valid <= 1'b0;
      end
    end
  end
endmodule : ddsl_fifo
`default_nettype wire

// ---- test/ddsl_monitor.sv ----
// Port checker for ddsl_top, attached by bind.
// Assumes one clock domain and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ddsl_monitor
  import ddsl_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Serial pins
  input wire logic i_sclk,
  input wire logic i_sync_n,
  input wire logic i_load_strobe_n,
  input wire logic o_serial_out,
  // Converter side
  input wire logic [WORD_W-1:0] o_dac_code,
  input wire logic o_dac_valid,
  input wire logic [WORD_W-1:0] o_dac_data,
  input wire logic i_dac_ready,
  input wire logic o_rising_sel,
  input wire logic o_daisy_mode,
  input wire logic o_update_pending
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  property p_rst;
    disable iff (1'b0) !i_rst_n |=> o_dac_code == WORD_RST && !o_dac_valid
      && o_rising_sel == RISING_RST && o_daisy_mode == DAISY_RST;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_load;
    $fell(i_load_strobe_n) |-> ##[2:10] o_update_pending;
  endproperty
  a_load: assert property (p_load) else $error("strobe fall gave no update");
  property p_daisy;
    o_daisy_mode && !i_load_strobe_n && $rose(i_sync_n) |-> ##[2:10] o_update_pending;
  endproperty
  a_daisy: assert property (p_daisy) else $error("frame end gave no update");
  property p_cause;
    $rose(o_update_pending) |-> !$past(i_load_strobe_n, 4);
  endproperty
  a_cause: assert property (p_cause) else $error("update with strobe high");
  property p_hold;
    o_dac_valid && !i_dac_ready |=> o_dac_valid && $stable(o_dac_data);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled head word moved");
  property p_sel;
    $changed(o_rising_sel) |-> !$past(i_sync_n, 5);
  endproperty
  a_sel: assert property (p_sel) else $error("edge select changed outside frame");
  property p_dsy;
    $changed(o_daisy_mode) |-> !$past(i_sync_n, 5);
  endproperty
  a_dsy: assert property (p_dsy) else $error("mode changed outside frame");
  property p_sout;
    $changed(o_serial_out) |-> $past(i_sclk, 2) != o_rising_sel;
  endproperty
  a_sout: assert property (p_sout) else $error("serial out moved on sampling edge");
  c_pend: cover property ($rose(o_update_pending));
  c_rise: cover property ($rose(o_rising_sel));
  c_dsy: cover property ($rose(o_daisy_mode));
endmodule : ddsl_monitor
`default_nettype wire

// ---- test/ddsl_host.sv ----
// Host serial port model driving sclk, frame select and data.
// Assumes calls start just after an i_mclk edge; sclk idles low between frames.
`timescale 1ns/1ps
`default_nettype none
module ddsl_host (
  // Serial pins toward the device
  output logic o_sclk,
  output logic o_sync_n,
  output logic o_sdata
);
  initial begin
    o_sclk = 1'b0;
    o_sync_n = 1'b1;
    o_sdata = 1'b0;
  end
  // Each bit is valid only around the edge named by rise, so a wrong edge reads garbage.
  task automatic send(input logic [31:0] w, input int n, input logic rise);
    logic b;
    o_sync_n = 1'b0;
    #80;
    for (int i = n - 1; i >= 0; i--) begin
      b = w[i];
      o_sdata = rise ? b : ~b;
      #40 o_sclk = 1'b1;
      #40 o_sdata = rise ? ~b : b;
      #40 o_sclk = 1'b0;
      #40;
    end
    o_sync_n = 1'b1;
    o_sdata = ~b;
    #80;
  endtask : send
endmodule : ddsl_host
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for ddsl_top with a host model on the serial pins.
// Assumes the FIFO holds 16 words plus a head register.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ddsl_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_load_strobe_n = 1'b1;
  logic i_dac_ready = 1'b0;
  logic rdy = 1'b0;
  wire logic sclk, sync_n, sdata, o_serial_out, o_dac_valid;
  wire logic o_rising_sel, o_daisy_mode, o_update_pending;
  wire logic [WORD_W-1:0] o_dac_code, o_dac_data;
  logic [WORD_W-1:0] bufw, last, q[$];
  logic [31:0] dd;
  int err_count = 0;
  int compares = 0;
  always #2 i_mclk = ~i_mclk;
  ddsl_host host (.o_sclk(sclk), .o_sync_n(sync_n), .o_sdata(sdata));
  ddsl_top DUT (.i_mclk, .i_rst_n, .i_sclk(sclk), .i_sync_n(sync_n), .i_serial_in(sdata),
    .i_load_strobe_n, .o_serial_out, .o_dac_code, .o_dac_valid, .o_dac_data, .i_dac_ready,
    .o_rising_sel, .o_daisy_mode, .o_update_pending);
  task automatic chk(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  function automatic logic [15:0] dw(input logic [31:0] r);
    dw = (r[15:12] == CTRL_CODE) ? r[15:0] ^ 16'h8000 : r[15:0];
  endfunction : dw
  // The last opposite edge of a frame shows the bit sent one word length before its end.
  function automatic logic sout_exp(input logic [31:0] d, input int n);
    sout_exp = d[n - WORD_W];
  endfunction : sout_exp
  task automatic rst;
    i_rst_n = 1'b0;
    i_load_strobe_n = 1'b1;
    q.delete();
    bufw = WORD_RST;
    last = WORD_RST;
    repeat (16) @(posedge i_mclk);
    #1 i_rst_n = 1'b1;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask : rst
  // Words are queued before the device can see them, so the drain never runs ahead.
  task automatic ld(input logic v);
    if (!v && i_load_strobe_n) begin
      q.push_back(bufw);
      last = bufw;
    end
    i_load_strobe_n = v;
    repeat (12) @(posedge i_mclk);
    #1;
  endtask : ld
  task automatic frame(input logic [31:0] d, input int n, input logic rise, input logic ck);
    if (n >= 16 && d[15:12] != CTRL_CODE) begin
      bufw = d[15:0];
      if (!i_load_strobe_n) begin
        q.push_back(bufw);
        last = bufw;
      end
    end
    host.send(d, n, rise);
    repeat (20) @(posedge i_mclk);
    #1;
    if (ck) chk(o_dac_code, last);
  endtask : frame
  always @(posedge i_mclk) begin
    if (i_rst_n && o_dac_valid === 1'b1 && i_dac_ready) chk(o_dac_data, q.pop_front());
    #1 i_dac_ready = rdy & 1'($urandom);
  end
  initial begin
    #300000;
    err_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h348b));
    rst();
    chk(o_dac_code, WORD_RST);
    chk(16'({o_rising_sel, o_daisy_mode}), 16'({RISING_RST, DAISY_RST}));
    rdy = 1'b1;
    for (int k = 0; k < 3; k++) begin
      frame({16'h0000, dw($urandom)}, 16, 1'b0, 1'b1);
      ld(1'b0);
      chk(o_dac_code, last);
      ld(1'b1);
    end
    ld(1'b0);
    frame({16'h0000, dw($urandom)}, 15, 1'b0, 1'b1);
    repeat (4) frame({16'h0000, dw($urandom)}, 16, 1'b0, 1'b1);
    chk(16'(q.size()), 16'h0000);
    rdy = 1'b0;
    repeat (17) frame({16'h0000, dw($urandom)}, 16, 1'b0, 1'b1);
    chk(16'(o_update_pending), 16'h0000);
    frame({16'h0000, dw($urandom)}, 16, 1'b0, 1'b0);
    chk(16'(o_update_pending), 16'h0001);
    rdy = 1'b1;
    repeat (300) @(posedge i_mclk);
    #1;
    chk(o_dac_code, last);
    chk(16'(q.size()), 16'h0000);
    frame({16'h0000, CTRL_CODE, 12'h001}, 16, 1'b0, 1'b1);
    chk(16'(o_rising_sel), 16'h0001);
    frame({16'h0000, dw($urandom)}, 16, 1'b1, 1'b1);
    rst();
    frame({16'h0000, CTRL_CODE, 12'h002}, 16, 1'b0, 1'b1);
    chk(16'(o_daisy_mode), 16'h0001);
    ld(1'b0);
    dd = {dw($urandom), dw($urandom)};
    frame(dd, 32, 1'b0, 1'b1);
    chk(16'(o_serial_out), 16'(sout_exp(dd, 32)));
    wrap_up();
  end
endmodule : tb
bind ddsl_top ddsl_monitor u_mon (.i_mclk, .i_rst_n, .i_sclk, .i_sync_n, .i_load_strobe_n,
  .o_serial_out, .o_dac_code, .o_dac_valid, .o_dac_data, .i_dac_ready, .o_rising_sel,
  .o_daisy_mode, .o_update_pending);
`default_nettype wire
